// ### hdl/p5t_device.sv
`timescale 1ns/100ps
`default_nettype none
`include "p5t_params.svh"
module p5t_device #(
   parameter int unsigned TIMER_CYC = `P5T_TIMER_CYC
) (
   input  wire logic             sys_clk,
   input  wire logic             resetn,
   p5t_link_if.dev               link,
   input  wire p5t_pkg::p5t_ch_t rx_line,
   output var  p5t_pkg::p5t_ch_t sync_pulse,
   output logic                  arch_raw
);
   import p5t_pkg::*;
   localparam int NCH = `P5T_NCH;
   localparam int FB  = `P5T_FRAME_BITS;
   localparam int SB  = `P5T_SPI_BITS;
   // Pin synchronisers reset to the pins' idle levels, so no false edge follows reset
   logic [6:0]  sy1_r, sy2_r;
   logic        sclk_s, csn_s, mosi_s;
   p5t_ch_t     trg_s, rx_s;
   assign sclk_s = sy2_r[0];
   assign csn_s  = sy2_r[1];
   assign mosi_s = sy2_r[2];
   assign trg_s  = sy2_r[4:3];
   assign rx_s   = sy2_r[6:5];
   logic        sclk_d_r, sclk_d_nxt, csn_d_r, csn_d_nxt, miso_r, miso_nxt;
   logic        mode_r, mode_nxt, tmr_en_r, tmr_en_nxt;
   logic [4:0]  bcnt_r, bcnt_nxt;
   p5t_word_t   rxs_r, rxs_nxt, txs_r, txs_nxt, resp_r, resp_nxt;
   p5t_ch_t     en_r, en_nxt, long_r, long_nxt;
   p5t_ch_t     trig_spi, set_mask, pop, ovr_clr, head_v, ovr, mask;
   p5t_frame_t  head_d [NCH];
   p5t_cmd_t    cmd;
   logic        rd_ch;
   // Automatic sync timer fires in mode zero only
   logic [15:0] tmr_r, tmr_nxt;
   logic        tmr_tick;
   p5t_ch_t     dout_r, dout_nxt;
   assign cmd      = p5t_cmd_t'(rxs_r[`P5T_CMD_HI:`P5T_CMD_LO]);
   assign rd_ch    = rxs_r[0];
   assign tmr_tick = tmr_en_r && !mode_r && tmr_r == 16'(TIMER_CYC - 1);
   always_comb begin
      tmr_nxt    = (tmr_tick || !tmr_en_r) ? 16'h0000 : tmr_r + 16'h0001;
      dout_nxt   = mode_r ? (rx_s & en_r) : '0;
      sclk_d_nxt = sclk_s;
      csn_d_nxt  = csn_s;
      miso_nxt   = miso_r;
      bcnt_nxt   = bcnt_r;
      rxs_nxt    = rxs_r;
      txs_nxt    = txs_r;
      resp_nxt   = resp_r;
      mode_nxt   = mode_r;
      en_nxt     = en_r;
      tmr_en_nxt = tmr_en_r;
      long_nxt   = long_r;
      trig_spi   = '0;
      set_mask   = '0;
      pop        = '0;
      ovr_clr    = '0;
      if (csn_d_r && !csn_s) begin
         txs_nxt  = resp_r;
         miso_nxt = resp_r[SB-1];
         bcnt_nxt = '0;
      end else if (!csn_s && sclk_s && !sclk_d_r) begin
         rxs_nxt  = {rxs_r[SB-2:0], mosi_s};
         bcnt_nxt = bcnt_r + 5'h1;
      end else if (!csn_s && !sclk_s && sclk_d_r) begin
         txs_nxt  = {txs_r[SB-2:0], 1'b0};
         miso_nxt = txs_r[SB-2];
      end else if (!csn_d_r && csn_s && bcnt_r == 5'(SB)) begin
         case (cmd)
            P5T_CMD_CFG: begin
               mode_nxt   = rxs_r[`P5T_CFG_MODE];
               en_nxt     = rxs_r[`P5T_CFG_EN_LO +: NCH];
               tmr_en_nxt = rxs_r[`P5T_CFG_TMR];
               long_nxt   = rxs_r[`P5T_CFG_LONG_LO +: NCH];
            end
            P5T_CMD_TRIG: trig_spi = rxs_r[NCH-1:0];
            P5T_CMD_MASK: set_mask = rxs_r[NCH-1:0];
            P5T_CMD_READ: begin
               pop[rd_ch]     = 1'b1;
               ovr_clr[rd_ch] = 1'b1;
               resp_nxt = {head_v[rd_ch], rd_ch, ovr[rd_ch], 3'h0, head_d[rd_ch]};
            end
            P5T_CMD_STAT: resp_nxt = {mode_r, en_r, tmr_en_r, long_r, mask, head_v, ovr, 4'h0};
            default: resp_nxt = resp_r;
         endcase
      end
   end
   always_ff @(posedge sys_clk or negedge resetn) begin
      if (!resetn) begin
         sy1_r    <= 7'h02;
         sy2_r    <= 7'h02;
         tmr_r    <= 16'h0000;
         dout_r   <= 2'h0;
         sclk_d_r <= 1'b0;
         csn_d_r  <= 1'b1;
         miso_r   <= 1'b0;
         bcnt_r   <= 5'h0;
         rxs_r    <= 16'h0000;
         txs_r    <= 16'h0000;
         resp_r   <= 16'h0000;
         mode_r   <= 1'b0;
         en_r     <= 2'h0;
         tmr_en_r <= 1'b0;
         long_r   <= 2'h0;
      end else begin
         sy1_r    <= {rx_line, link.sync_trig, link.mosi, link.cs_n, link.sclk};
         sy2_r    <= sy1_r;
         tmr_r    <= tmr_nxt;
         dout_r   <= dout_nxt;
         sclk_d_r <= sclk_d_nxt;
         csn_d_r  <= csn_d_nxt;
         miso_r   <= miso_nxt;
         bcnt_r   <= bcnt_nxt;
         rxs_r    <= rxs_nxt;
         txs_r    <= txs_nxt;
         resp_r   <= resp_nxt;
         mode_r   <= mode_nxt;
         en_r     <= en_nxt;
         tmr_en_r <= tmr_en_nxt;
         long_r   <= long_nxt;
      end
   end
   assign link.miso = miso_r;
   assign arch_raw  = mode_r;
   assign link.dout = dout_r;
   for (genvar c = 0; c < NCH; c++) begin : g_ch
      // Decoder: integrated high time of each half bit decides the bit, so
      // mark/space duty distortion on the line is corrected.
      p5t_dec_t   st_r, st_nxt;
      logic [7:0] cnt_r, cnt_nxt;
      logic [8:0] sc_r, sc_nxt;
      logic [3:0] nb_r, nb_nxt;
      p5t_frame_t shf_r, shf_nxt, dw_r, dw_nxt;
      logic       dv_r, dv_nxt, ov_r, ov_nxt, rxd_r, run, rdy;
      logic [8:0] sc_new;
      assign run = en_r[c] && !mode_r;
      always_comb begin
         st_nxt  = st_r;
         cnt_nxt = cnt_r;
         sc_nxt  = sc_r;
         nb_nxt  = nb_r;
         shf_nxt = shf_r;
         dw_nxt  = dw_r;
         dv_nxt  = dv_r && !rdy;
         ov_nxt  = ov_r && !ovr_clr[c];
         sc_new  = (cnt_r < 8'(`P5T_BIT_CYC / 2)) ? sc_r - 9'(rx_s[c]) : sc_r + 9'(rx_s[c]);
         case (st_r)
            P5T_DEC_IDLE: if (run && rx_s[c] && !rxd_r) begin
               st_nxt  = P5T_DEC_BIT;
               cnt_nxt = 8'h00;
               sc_nxt  = 9'h000;
               nb_nxt  = 4'h0;
            end
            P5T_DEC_BIT: if (!run) begin
               st_nxt = P5T_DEC_IDLE;
            end else if (cnt_r == 8'(`P5T_BIT_CYC - 1)) begin
               cnt_nxt = 8'h00;
               sc_nxt  = 9'h000;
               nb_nxt  = nb_r + 4'h1;
               shf_nxt = {shf_r[FB-2:0], !sc_new[8] && sc_new != 9'h000};
               if (nb_r == 4'(FB - 1)) begin
                  st_nxt = P5T_DEC_IDLE;
                  if (dv_nxt) ov_nxt = 1'b1;
                  else begin
                     dv_nxt = 1'b1;
                     dw_nxt = shf_nxt;
                  end
               end
            end else begin
               cnt_nxt = cnt_r + 8'h01;
               sc_nxt  = sc_new;
            end
            default: st_nxt = P5T_DEC_IDLE;
         endcase
      end
      always_ff @(posedge sys_clk or negedge resetn) begin
         if (!resetn) begin
            st_r  <= P5T_DEC_IDLE;
            cnt_r <= 8'h00;
            sc_r  <= 9'h000;
            nb_r  <= 4'h0;
            shf_r <= '0;
            dw_r  <= '0;
            dv_r  <= 1'b0;
            ov_r  <= 1'b0;
            rxd_r <= 1'b0;
         end else begin
            st_r  <= st_nxt;
            cnt_r <= cnt_nxt;
            sc_r  <= sc_nxt;
            nb_r  <= nb_nxt;
            shf_r <= shf_nxt;
            dw_r  <= dw_nxt;
            dv_r  <= dv_nxt;
            ov_r  <= ov_nxt;
            rxd_r <= rx_s[c];
         end
      end
      assign ovr[c] = ov_r;
      // Two-entry receive buffer; full stalls the decoder's hand-over
      p5t_frame_t mem_r [2];
      p5t_frame_t mem_nxt [2];
      logic       wp_r, wp_nxt, rp_r, rp_nxt;
      logic [1:0] fc_r, fc_nxt;
      logic       push, pull;
      assign rdy  = fc_r != 2'h2;
      assign push = dv_r && rdy;
      assign pull = pop[c] && fc_r != 2'h0;
      always_comb begin
         mem_nxt = mem_r;
         wp_nxt  = wp_r ^ push;
         rp_nxt  = rp_r ^ pull;
         fc_nxt  = fc_r + 2'(push) - 2'(pull);
         if (push) mem_nxt[wp_r] = dw_r;
      end
      always_ff @(posedge sys_clk or negedge resetn) begin
         if (!resetn) begin
            mem_r <= '{default: '0};
            wp_r  <= 1'b0;
            rp_r  <= 1'b0;
            fc_r  <= 2'h0;
         end else begin
            mem_r <= mem_nxt;
            wp_r  <= wp_nxt;
            rp_r  <= rp_nxt;
            fc_r  <= fc_nxt;
         end
      end
      assign head_v[c] = fc_r != 2'h0;
      assign head_d[c] = mem_r[rp_r];
      // Sync pulse generator
      logic [7:0] pc_r, pc_nxt;
      logic       mk_r, mk_nxt, pls_r, pls_nxt, trd_r, fire;
      assign fire = en_r[c] && !mode_r && !pls_r &&
                    (trig_spi[c] || (trg_s[c] && !trd_r) || tmr_tick);
      always_comb begin
         pc_nxt  = pc_r;
         pls_nxt = pls_r;
         mk_nxt  = mk_r || set_mask[c];
         if (mode_r) begin
            pls_nxt = en_r[c] && trg_s[c];
         end else if (fire && mk_r) begin
            mk_nxt = set_mask[c];
         end else if (fire) begin
            pls_nxt = 1'b1;
            pc_nxt  = long_r[c] ? 8'(`P5T_LONG_CYC - 1) : 8'(`P5T_SHORT_CYC - 1);
         end else if (pls_r) begin
            pls_nxt = pc_r != 8'h00 && en_r[c];
            pc_nxt  = pc_r - 8'h01;
         end
      end
      always_ff @(posedge sys_clk or negedge resetn) begin
         if (!resetn) begin
            pc_r  <= 8'h00;
            mk_r  <= 1'b0;
            pls_r <= 1'b0;
            trd_r <= 1'b0;
         end else begin
            pc_r  <= pc_nxt;
            mk_r  <= mk_nxt;
            pls_r <= pls_nxt;
            trd_r <= trg_s[c];
         end
      end
      assign mask[c]       = mk_r;
      assign sync_pulse[c] = pls_r;
   end
endmodule : p5t_device
`default_nettype wire

// ### hdl/p5t_host.sv
`timescale 1ns/100ps
`default_nettype none
`include "p5t_params.svh"
module p5t_host (
   input  wire logic              sys_clk,
   input  wire logic              resetn,
   p5t_link_if.mcu                link,
   input  wire logic              cmd_valid,
   output logic                   cmd_ready,
   input  wire p5t_pkg::p5t_word_t cmd_word,
   output logic                   rsp_valid,
   output var  p5t_pkg::p5t_word_t rsp_word,
   input  wire p5t_pkg::p5t_ch_t  trig_req,
   output var  p5t_pkg::p5t_ch_t  raw_bit
);
   import p5t_pkg::*;

   localparam int SB = `P5T_SPI_BITS;

   // Synchronisers for miso and the raw streams
   logic [2:0] sy1_r, sy2_r;
   always_ff @(posedge sys_clk or negedge resetn) begin
      if (!resetn) begin
         sy1_r <= 3'h0;
         sy2_r <= 3'h0;
      end else begin
         sy1_r <= {link.dout, link.miso};
         sy2_r <= sy1_r;
      end
   end

   p5t_spi_t   st_r, st_nxt;
   logic [3:0] div_r, div_nxt;
   logic [5:0] ecnt_r, ecnt_nxt;
   logic       sclk_r, sclk_nxt, csn_r, csn_nxt, mosi_r, mosi_nxt, rv_r, rv_nxt, tick;
   p5t_word_t  tx_r, tx_nxt, rx_r, rx_nxt;
   p5t_ch_t    trg_r, raw_r;

   assign tick      = div_r == 4'(`P5T_SCLK_HALF - 1);
   assign cmd_ready = st_r == P5T_SPI_IDLE;

   always_comb begin
      st_nxt   = st_r;
      div_nxt  = tick ? 4'h0 : div_r + 4'h1;
      ecnt_nxt = ecnt_r;
      sclk_nxt = sclk_r;
      csn_nxt  = csn_r;
      mosi_nxt = mosi_r;
      tx_nxt   = tx_r;
      rx_nxt   = rx_r;
      rv_nxt   = 1'b0;
      case (st_r)
         P5T_SPI_IDLE: if (cmd_valid) begin
            st_nxt   = P5T_SPI_SHIFT;
            div_nxt  = 4'h0;
            ecnt_nxt = 6'h00;
            csn_nxt  = 1'b0;
            tx_nxt   = cmd_word;
            mosi_nxt = cmd_word[SB-1];
         end
         P5T_SPI_SHIFT: if (tick) begin
            sclk_nxt = !sclk_r;
            ecnt_nxt = ecnt_r + 6'h01;
            if (!sclk_r) begin
               rx_nxt = {rx_r[SB-2:0], sy2_r[0]};
            end else begin
               tx_nxt   = {tx_r[SB-2:0], 1'b0};
               mosi_nxt = tx_r[SB-2];
               if (ecnt_r == 6'(2 * SB - 1)) st_nxt = P5T_SPI_END;
            end
         end
         P5T_SPI_END: if (tick) begin
            csn_nxt = 1'b1;
            rv_nxt  = 1'b1;
            st_nxt  = P5T_SPI_GAP;
         end
         P5T_SPI_GAP: if (tick) st_nxt = P5T_SPI_IDLE;
         default: st_nxt = P5T_SPI_IDLE;
      endcase
   end

   always_ff @(posedge sys_clk or negedge resetn) begin
      if (!resetn) begin
         st_r   <= P5T_SPI_IDLE;
         div_r  <= 4'h0;
         ecnt_r <= 6'h00;
         sclk_r <= 1'b0;
         csn_r  <= 1'b1;
         mosi_r <= 1'b0;
         tx_r   <= 16'h0000;
         rx_r   <= 16'h0000;
         rv_r   <= 1'b0;
         trg_r  <= 2'h0;
         raw_r  <= 2'h0;
      end else begin
         st_r   <= st_nxt;
         div_r  <= div_nxt;
         ecnt_r <= ecnt_nxt;
         sclk_r <= sclk_nxt;
         csn_r  <= csn_nxt;
         mosi_r <= mosi_nxt;
         tx_r   <= tx_nxt;
         rx_r   <= rx_nxt;
         rv_r   <= rv_nxt;
         trg_r  <= trig_req;
         raw_r  <= sy2_r[2:1];
      end
   end

   assign link.sclk      = sclk_r;
   assign link.cs_n      = csn_r;
   assign link.mosi      = mosi_r;
   assign link.sync_trig = trg_r;
   assign rsp_valid      = rv_r;
   assign rsp_word       = rx_r;
   assign raw_bit        = raw_r;
endmodule : p5t_host
`default_nettype wire

// ### hdl/p5t_link_if.sv
`timescale 1ns/100ps
`default_nettype none
interface p5t_link_if;
   logic                 sclk;
   logic                 cs_n;
   logic                 mosi;
   logic                 miso;
   p5t_pkg::p5t_ch_t     dout;
   p5t_pkg::p5t_ch_t     sync_trig;
   modport dev (input sclk, input cs_n, input mosi, input sync_trig, output miso, output dout);
   modport mcu (output sclk, output cs_n, output mosi, output sync_trig, input miso, input dout);
endinterface : p5t_link_if
`default_nettype wire

// ### hdl/p5t_params.svh
`ifndef P5T_PARAMS_SVH
`define P5T_PARAMS_SVH

`define P5T_NCH         2
`define P5T_CLK_NS      50
`define P5T_BIT_NS      8000
`define P5T_BIT_CYC     (`P5T_BIT_NS / `P5T_CLK_NS)
`define P5T_SHORT_NS    4000
`define P5T_SHORT_CYC   ((`P5T_SHORT_NS + `P5T_CLK_NS - 1) / `P5T_CLK_NS)
`define P5T_LONG_NS     8000
`define P5T_LONG_CYC    ((`P5T_LONG_NS + `P5T_CLK_NS - 1) / `P5T_CLK_NS)
`define P5T_TIMER_NS    500000
`define P5T_TIMER_CYC   (`P5T_TIMER_NS / `P5T_CLK_NS)
`define P5T_FRAME_BITS  10
`define P5T_SPI_BITS    16
`define P5T_SCLK_HALF   8
`define P5T_CMD_HI      15
`define P5T_CMD_LO      12
`define P5T_CFG_MODE    0
`define P5T_CFG_EN_LO   1
`define P5T_CFG_TMR     3
`define P5T_CFG_LONG_LO 4

`endif

// ### hdl/p5t_pkg.sv
`include "p5t_params.svh"
package p5t_pkg;
   typedef logic [`P5T_NCH-1:0]        p5t_ch_t;
   typedef logic [`P5T_SPI_BITS-1:0]   p5t_word_t;
   typedef logic [`P5T_FRAME_BITS-1:0] p5t_frame_t;
   typedef enum logic [3:0] {
      P5T_CMD_NOP  = 4'h0,
      P5T_CMD_CFG  = 4'h1,
      P5T_CMD_TRIG = 4'h2,
      P5T_CMD_MASK = 4'h3,
      P5T_CMD_READ = 4'h4,
      P5T_CMD_STAT = 4'h5
   } p5t_cmd_t;
   typedef enum logic {
      P5T_DEC_IDLE = 1'b0,
      P5T_DEC_BIT  = 1'b1
   } p5t_dec_t;
   typedef enum logic [1:0] {
      P5T_SPI_IDLE  = 2'h0,
      P5T_SPI_SHIFT = 2'h1,
      P5T_SPI_END   = 2'h2,
      P5T_SPI_GAP   = 2'h3
   } p5t_spi_t;
endpackage : p5t_pkg

// ### verif/p5t_bench.sv
`timescale 1ns/100ps
`default_nettype none
module p5t_bench;
   import p5t_pkg::*;
   logic      sys_clk;
   logic      resetn;
   logic      cmd_valid;
   logic      cmd_ready;
   p5t_word_t cmd_word;
   logic      rsp_valid;
   p5t_word_t rsp_word;
   p5t_ch_t   trig_req;
   p5t_ch_t   raw_bit;
   p5t_ch_t   rx_line;
   p5t_ch_t   sync_pulse;
   logic      arch_raw;
   p5t_word_t r;
   int        n;
   int        miscompares;
   int        num_checks;

   p5t_link_if u_p5t_link_if ();

   p5t_device #(.TIMER_CYC(50)) u_p5t_device (
      .sys_clk    (sys_clk),
      .resetn     (resetn),
      .link       (u_p5t_link_if),
      .rx_line    (rx_line),
      .sync_pulse (sync_pulse),
      .arch_raw   (arch_raw)
   );

   p5t_host u_p5t_host (
      .sys_clk   (sys_clk),
      .resetn    (resetn),
      .link      (u_p5t_link_if),
      .cmd_valid (cmd_valid),
      .cmd_ready (cmd_ready),
      .cmd_word  (cmd_word),
      .rsp_valid (rsp_valid),
      .rsp_word  (rsp_word),
      .trig_req  (trig_req),
      .raw_bit   (raw_bit)
   );

   p5t_link_props u_p5t_link_props (
      .sys_clk   (sys_clk),
      .resetn    (resetn),
      .sclk      (u_p5t_link_if.sclk),
      .cs_n      (u_p5t_link_if.cs_n),
      .mosi      (u_p5t_link_if.mosi),
      .miso      (u_p5t_link_if.miso),
      .dout      (u_p5t_link_if.dout),
      .sync_trig (u_p5t_link_if.sync_trig)
   );

   always #25 sys_clk = ~sys_clk;

   task automatic test_done;
      if (miscompares == 0 && num_checks > 0) begin
         $display("Testbench passed");
      end else begin
         $display("Testbench failed");
      end
      $finish;
   endtask : test_done

   task automatic check(input logic [15:0] seen, input logic [15:0] exp);
      num_checks++;
      if (seen !== exp) begin
         miscompares++;
         $display("MISMATCH t=%0t seen=%h expected=%h", $time, seen, exp);
      end
   endtask : check

   // One full frame; returns the answer to the previous command
   task automatic xfer(input p5t_word_t w, output p5t_word_t rd);
      int i;
      for (i = 0; i < 400 && cmd_ready !== 1'b1; i++) @(negedge sys_clk);
      cmd_valid = 1'b1;
      cmd_word  = w;
      @(negedge sys_clk);
      cmd_valid = 1'b0;
      for (i = 0; i < 400 && rsp_valid !== 1'b1; i++) @(negedge sys_clk);
      if (rsp_valid !== 1'b1) begin
         miscompares++;
         test_done();
      end
      rd = rsp_word;
   endtask : xfer

   task automatic pulse_len(input int ch, output int len);
      int i;
      len = 0;
      for (i = 0; i < 400 && sync_pulse[ch] === 1'b1; i++) @(negedge sys_clk);
      for (i = 0; i < 600 && sync_pulse[ch] !== 1'b1; i++) @(negedge sys_clk);
      while (sync_pulse[ch] === 1'b1 && len < 400) begin
         len++;
         @(negedge sys_clk);
      end
   endtask : pulse_len

   // Manchester frame, one three-cycle glitch in bit 5's first half; raw output probed mid-half
   task automatic send_frame(input int ch, input logic [9:0] f, input logic raw);
      int   b;
      int   h;
      logic lvl;
      for (b = 9; b >= 0; b--) begin
         for (h = 0; h < 2; h++) begin
            lvl = (h == 0) ? ~f[b] : f[b];
            rx_line[ch] = lvl;
            repeat (40) @(negedge sys_clk);
            check({15'h0, raw_bit[ch]}, {15'h0, raw & lvl});
            repeat (20) @(negedge sys_clk);
            if (b == 5 && h == 0) rx_line[ch] = ~lvl;
            repeat (3) @(negedge sys_clk);
            rx_line[ch] = lvl;
            repeat (17) @(negedge sys_clk);
         end
      end
      rx_line[ch] = 1'b0;
   endtask : send_frame

   initial begin
      sys_clk     = 1'b0;
      resetn      = 1'b0;
      cmd_valid   = 1'b0;
      cmd_word    = 16'h0000;
      trig_req    = 2'h0;
      rx_line     = 2'h0;
      miscompares = 0;
      num_checks  = 0;
      repeat (10) @(posedge sys_clk);
      @(negedge sys_clk);
      resetn = 1'b1;
      check({10'h0, arch_raw, sync_pulse, raw_bit, rsp_valid}, 16'h0000);
      xfer(16'h5000, r);
      xfer(16'h0000, r);
      check(r, 16'h0000);
      fork
         xfer(16'h2003, r);
         pulse_len(0, n);
      join
      check(16'(n), 16'h0000);
      xfer(16'h1026, r);
      xfer(16'h5000, r);
      xfer(16'h0000, r);
      check(r, 16'h6800);
      for (int c = 0; c < 2; c++) begin
         fork
            xfer(p5t_word_t'(16'h2000 | (16'h0001 << c)), r);
            pulse_len(c, n);
         join
         check(16'(n), (c == 1) ? 16'h00A0 : 16'h0050);
      end
      xfer(16'h3001, r);
      for (int k = 0; k < 2; k++) begin
         fork
            xfer(16'h2001, r);
            pulse_len(0, n);
         join
         check(16'(n), (k == 0) ? 16'h0000 : 16'h0050);
      end
      fork
         begin
            trig_req = 2'h2;
            repeat (300) @(negedge sys_clk);
            trig_req = 2'h0;
         end
         pulse_len(1, n);
      join
      check(16'(n), 16'h00A0);
      xfer(16'h100A, r);
      pulse_len(0, n);
      check(16'(n), 16'h0050);
      xfer(16'h1006, r);
      send_frame(0, 10'h0B5, 1'b0);
      repeat (200) @(negedge sys_clk);
      xfer(16'h4000, r);
      xfer(16'h0000, r);
      check(r, 16'h80B5);
      xfer(16'h1007, r);
      repeat (10) @(negedge sys_clk);
      check({15'h0, arch_raw}, 16'h0001);
      send_frame(0, 10'h0B5, 1'b1);
      repeat (200) @(negedge sys_clk);
      xfer(16'h4000, r);
      xfer(16'h0000, r);
      check({15'h0, r[15]}, 16'h0000);
      trig_req = 2'h1;
      repeat (10) @(negedge sys_clk);
      check({14'h0, sync_pulse}, 16'h0001);
      trig_req = 2'h0;
      repeat (10) @(negedge sys_clk);
      check({14'h0, sync_pulse}, 16'h0000);
      test_done();
   end
endmodule : p5t_bench
`default_nettype wire

// ### verif/p5t_link_props.sv
`timescale 1ns/100ps
`default_nettype none
module p5t_link_props
   import p5t_pkg::*;
(
   input wire logic             sys_clk,
   input wire logic             resetn,
   input wire logic             sclk,
   input wire logic             cs_n,
   input wire logic             mosi,
   input wire logic             miso,
   input wire p5t_pkg::p5t_ch_t dout,
   input wire p5t_pkg::p5t_ch_t sync_trig
);
   logic       sclk_d_r;
   logic       sclk_d_nxt;
   logic [4:0] rise_cnt_r;
   logic [4:0] rise_cnt_nxt;

   // Counts clock rises within one chip-select frame
   always_comb begin
      sclk_d_nxt   = sclk;
      rise_cnt_nxt = rise_cnt_r;
      if (cs_n) begin
         rise_cnt_nxt = 5'h00;
      end else if (sclk && !sclk_d_r) begin
         rise_cnt_nxt = rise_cnt_r + 5'h01;
      end
   end

   always_ff @(posedge sys_clk or negedge resetn) begin
      if (!resetn) begin
         sclk_d_r   <= 1'b0;
         rise_cnt_r <= 5'h00;
      end else begin
         sclk_d_r   <= sclk_d_nxt;
         rise_cnt_r <= rise_cnt_nxt;
      end
   end

   default clocking cb @(posedge sys_clk);
   endclocking
   default disable iff (!resetn);

   AST_SCLK_IDLE: assert property (cs_n |-> !sclk)
      else $error("serial clock active while deselected");
   AST_SCLK_HIGH: assert property ($rose(sclk) |-> sclk [*8] ##1 !sclk)
      else $error("serial clock high phase not eight cycles");
   AST_SCLK_LOW: assert property ($fell(sclk) |-> !sclk [*8])
      else $error("serial clock low phase shorter than eight cycles");
   AST_CS_START: assert property ($fell(cs_n) |-> !sclk [*8] ##1 sclk)
      else $error("first clock rise not eight cycles after select");
   AST_CS_GAP: assert property ($rose(cs_n) |-> cs_n [*8])
      else $error("deselect gap shorter than eight cycles");
   AST_FRAME_LEN: assert property ($rose(cs_n) |-> rise_cnt_r == 5'h10)
      else $error("frame does not carry sixteen clock rises");
   AST_MOSI_STABLE: assert property ((!cs_n && sclk) |-> $stable(mosi))
      else $error("host data moved while serial clock high");
   AST_MISO_STABLE: assert property ((!cs_n && sclk) |-> $stable(miso))
      else $error("device data moved while serial clock high");
endmodule : p5t_link_props
`default_nettype wire
